// >>> hdl/fcl_consts.svh
// Offsets, field positions, defaults and timing counts of the fuse loader
`ifndef FCL_CONSTS_SVH
`define FCL_CONSTS_SVH

// Fuse byte offsets
`define FCL_OFS_WDT 4'h0
`define FCL_OFS_BOD 4'h1
`define FCL_OFS_OSC 4'h2
`define FCL_OFS_SYS0 4'h5
`define FCL_OFS_SYS1 4'h6
`define FCL_OFS_APP_END 4'h7
`define FCL_OFS_BOOT_END 4'h8
`define FCL_OFS_LOCK 4'hA
`define FCL_OFS_LAST 4'hA
`define FCL_FUSE_BYTES 11

// Watchdog fuse fields
`define FCL_WDT_WIN_HI 7
`define FCL_WDT_WIN_LO 4
`define FCL_WDT_PER_HI 3
`define FCL_WDT_PER_LO 0

// Brown-out fuse fields
`define FCL_BOD_LVL_HI 7
`define FCL_BOD_LVL_LO 5
`define FCL_BOD_SRATE 4
`define FCL_BOD_ACT_HI 3
`define FCL_BOD_ACT_LO 2
`define FCL_BOD_SLP_HI 1
`define FCL_BOD_SLP_LO 0

// Oscillator fuse fields and codes
`define FCL_OSC_LOCK 7
`define FCL_OSC_FREQ_HI 1
`define FCL_OSC_FREQ_LO 0
`define FCL_FREQ_16M 2'h1
`define FCL_FREQ_20M 2'h2

// Shipped contents and erased value
`define FCL_SHIP_WDT 8'h00
`define FCL_SHIP_BOD 8'h00
`define FCL_SHIP_OSC 8'h02
`define FCL_SHIP_SYS0 8'hE4
`define FCL_SHIP_OTHER 8'hFF
`define FCL_ERASED 8'hFF
`define FCL_RD_UNMAPPED 8'h00

// Start-up delay before the copy, in clock cycles
`define FCL_START_CYCLES 4

`endif

// >>> hdl/fcl_loader.sv
// Fuse store with processor and programming port access and start-up copy
`timescale 1ns/100ps
`include "fcl_consts.svh"

module fcl_loader #(
  parameter int START_CYCLES = `FCL_START_CYCLES,
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Processor read port
  input wire logic cpu_rd_en,
  input wire logic cpu_wr_en,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata_r,
  output logic cpu_rvalid_r,
  // Programming/debug port
  input wire logic pd_req,
  input wire fcl_pkg::fcl_pd_op_type pd_op,
  input wire logic [ADDR_W-1:0] pd_addr,
  input wire logic [7:0] pd_wdata,
  output logic [7:0] pd_rdata_r,
  output logic pd_done_r,
  // Factory calibration words and run-time calibration write
  input wire fcl_pkg::fcl_cal_type sig_cal16,
  input wire fcl_pkg::fcl_cal_type sig_cal20,
  input wire logic cal_wr_en,
  input wire fcl_pkg::fcl_cal_type cal_wdata,
  output logic cal_wr_rejected_r,
  // Target register fields
  output fcl_pkg::fcl_wdt_ctrl_type watchdog_control_a_r,
  output fcl_pkg::fcl_bod_ctrl_type brownout_control_r,
  output logic brownout_lvl_reserved_r,
  output fcl_pkg::fcl_osc_ctrl_type osc_ctrl_r,
  output fcl_pkg::fcl_cal_type osc_temp_cal_reg_r,
  output logic loaded_r
);

  // How the block works, for whoever picks it up next:
  // The fuse array is a small byte store that a reset never touches.
  // The processor and the programming port both read it through the same
  // kind of path: decode the offset, pick the byte, answer one cycle on.
  // Only the programming port may program or clear a byte; the processor
  // write strobe is decoded solely to void a read made in the same cycle.
  // After each reset a short settle wait runs, then one copy cycle moves
  // every configured field into its target register at the same edge.
  // Targets never track the array live. A byte programmed at run time
  // reaches the watchdog, brown-out detector and oscillator only through
  // the copy after the next reset, which keeps a half-written fuse from
  // disturbing a running system.
  // Reserved frequency codes load the 20 MHz calibration word.
  // Limitation: reserved fuse bits are stored exactly as written; the
  // programmer is trusted to write them as ones.
  // Limitation: offsets past the last fuse read as zero and never write.

  localparam int CNT_W = $clog2(START_CYCLES + 1);
  localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_CYCLES - 1);

  // Parameter values the logic cannot serve
  if (START_CYCLES < 1) begin : g_bad_start
    $error("START_CYCLES must be at least one");
  end
  if ((2 ** ADDR_W) < `FCL_FUSE_BYTES) begin : g_bad_addr
    $error("ADDR_W too narrow for the fuse map");
  end

  // Nonvolatile fuse array. It keeps its contents over reset and holds
  // the shipped image from power-up, so both ports can read it at once.
  // The image is a declaration value so that the programming port
  // process remains the only writer of the array.
  logic [7:0] fuse_mem [`FCL_FUSE_BYTES] = '{
    `FCL_OFS_WDT: `FCL_SHIP_WDT,
    `FCL_OFS_BOD: `FCL_SHIP_BOD,
    `FCL_OFS_OSC: `FCL_SHIP_OSC,
    `FCL_OFS_SYS0: `FCL_SHIP_SYS0,
    default: `FCL_SHIP_OTHER
  };

  // Sequencer state and the settle counter that delays the copy
  fcl_pkg::fcl_state_type state_r;
  fcl_pkg::fcl_state_type state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Address decode for both ports
  wire logic cpu_hit = (cpu_addr <= ADDR_W'(`FCL_OFS_LAST));
  wire logic pd_hit = (pd_addr <= ADDR_W'(`FCL_OFS_LAST));
  wire logic [7:0] cpu_byte = cpu_hit ? fuse_mem[cpu_addr]
                                      : `FCL_RD_UNMAPPED;
  wire logic [7:0] pd_byte = pd_hit ? fuse_mem[pd_addr]
                                    : `FCL_RD_UNMAPPED;

  // Programming port write strobes; the processor strobe only voids a read
  wire logic pd_prog = pd_req && pd_hit &&
                       (pd_op == fcl_pkg::FCL_PD_PROGRAM);
  wire logic pd_clear = pd_req && pd_hit &&
                        (pd_op == fcl_pkg::FCL_PD_CLEAR);
  wire logic [7:0] pd_new = pd_clear ? `FCL_ERASED : pd_wdata;
  wire logic cpu_wr_ignored = cpu_wr_en;

  // Accepted requests on each port; a write in the same cycle voids a
  // processor read, so a half-formed access never returns data
  wire logic cpu_take = cpu_rd_en && !cpu_wr_ignored;
  wire logic pd_rd_take = pd_req && (pd_op == fcl_pkg::FCL_PD_READ);
  wire logic pd_answer = pd_req && (pd_op != fcl_pkg::FCL_PD_NOP);

  // Copy strobe, the only path from fuses to targets
  wire logic copy_now = (state_r == fcl_pkg::FCL_ST_COPY);

  // Fuse fields as seen at the copy
  wire logic [7:0] wdt_fuse = fuse_mem[`FCL_OFS_WDT];
  wire logic [7:0] bod_fuse = fuse_mem[`FCL_OFS_BOD];
  wire logic [7:0] osc_fuse = fuse_mem[`FCL_OFS_OSC];

  wire logic [1:0] freq_code =
    osc_fuse[`FCL_OSC_FREQ_HI:`FCL_OSC_FREQ_LO];
  // Reserved frequency codes fall back to 20 MHz, the safer calibration
  wire logic sel_16m = (freq_code == `FCL_FREQ_16M);
  // Calibration word picked by the frequency code for the copy
  wire fcl_pkg::fcl_cal_type cal_load =
    sel_16m ? sig_cal16 : sig_cal20;

  wire logic [2:0] lvl_code =
    bod_fuse[`FCL_BOD_LVL_HI:`FCL_BOD_LVL_LO];
  wire logic lvl_defined = (lvl_code == 3'h0) || (lvl_code == 3'h2) ||
                           (lvl_code == 3'h7);

  // Target images assembled from the fuse bytes
  fcl_pkg::fcl_wdt_ctrl_type wdt_load;
  fcl_pkg::fcl_bod_ctrl_type bod_load;
  fcl_pkg::fcl_osc_ctrl_type osc_load;

  // Field mapping from fuse bytes to target fields
  always_comb begin
    // Watchdog control A: window and period
    wdt_load.window = wdt_fuse[`FCL_WDT_WIN_HI:`FCL_WDT_WIN_LO];
    wdt_load.period = wdt_fuse[`FCL_WDT_PER_HI:`FCL_WDT_PER_LO];
    // Brown-out control B: threshold level
    bod_load.brownout_threshold_sel = lvl_code;
    // Brown-out control A: sample rate, active and sleep modes
    bod_load.brownout_sample_rate_sel = bod_fuse[`FCL_BOD_SRATE];
    bod_load.active_mode =
      bod_fuse[`FCL_BOD_ACT_HI:`FCL_BOD_ACT_LO];
    bod_load.sleep_mode =
      bod_fuse[`FCL_BOD_SLP_HI:`FCL_BOD_SLP_LO];
    // Oscillator: calibration lock and frequency select
    osc_load.osc_cal_lock = osc_fuse[`FCL_OSC_LOCK];
    osc_load.osc_freq_sel = freq_code;
    osc_load.run_16m = sel_16m;
  end

  // Start-up sequencer: wait, copy once, then run until next reset
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      fcl_pkg::FCL_ST_WAIT: begin
        // Settle wait before the copy
        if (cnt_r == START_LAST) begin
          state_nxt = fcl_pkg::FCL_ST_COPY;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      fcl_pkg::FCL_ST_COPY: begin
        // Exactly one copy cycle per reset
        state_nxt = fcl_pkg::FCL_ST_RUN;
      end
      fcl_pkg::FCL_ST_RUN: begin
        // Stay here until the next reset
        state_nxt = fcl_pkg::FCL_ST_RUN;
      end
      default: begin
        state_nxt = fcl_pkg::FCL_ST_WAIT;
        cnt_nxt = '0;
      end
    endcase
  end

  // Sequencer registers; every reset restarts the settle wait
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= fcl_pkg::FCL_ST_WAIT;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Fuse writes come only from the programming port
  // Offsets past the last fuse are decoded away so they never alias
  always_ff @(posedge clk) begin
    if (pd_prog || pd_clear) begin
      fuse_mem[pd_addr] <= pd_new;
    end
  end

  // Processor reads; writes are dropped and only void a read in the same cycle
  // Read data holds until the next accepted read
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_rdata_r <= 8'h00;
      cpu_rvalid_r <= 1'h0;
    end else begin
      cpu_rvalid_r <= cpu_take;
      if (cpu_take) begin
        cpu_rdata_r <= cpu_byte;
      end
    end
  end

  // Programming port answers every read, program or clear request one cycle later
  // Nop requests get no answer, so an idle port stays quiet
  always_ff @(posedge clk) begin
    if (reset) begin
      pd_rdata_r <= 8'h00;
      pd_done_r <= 1'h0;
    end else begin
      pd_done_r <= pd_answer;
      if (pd_rd_take) begin
        pd_rdata_r <= pd_byte;
      end
    end
  end

  // Watchdog target; zero until the copy, so no stale setting survives
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_control_a_r <= '0;
    end else if (copy_now) begin
      watchdog_control_a_r <= wdt_load;
    end
  end

  // Brown-out targets; the reserved-level flag is loaded with the level
  always_ff @(posedge clk) begin
    if (reset) begin
      brownout_control_r <= '0;
      brownout_lvl_reserved_r <= 1'h0;
    end else if (copy_now) begin
      brownout_control_r <= bod_load;
      brownout_lvl_reserved_r <= !lvl_defined;
    end
  end

  // Run-time calibration writes; lock and sequencer state guard them
  wire logic cal_take = cal_wr_en && (state_r == fcl_pkg::FCL_ST_RUN) &&
                        !osc_ctrl_r.osc_cal_lock;
  // A refused write still pulses a flag so software sees it was dropped
  wire logic cal_refuse = cal_wr_en && !cal_take;

  // Oscillator selection and lock, loaded once per reset
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_ctrl_r <= '0;
    end else if (copy_now) begin
      osc_ctrl_r <= osc_load;
    end
  end

  // Calibration word: factory value at the copy, then unlocked writes
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_temp_cal_reg_r <= '0;
      cal_wr_rejected_r <= 1'h0;
    end else begin
      cal_wr_rejected_r <= cal_refuse;
      if (copy_now) begin
        osc_temp_cal_reg_r <= cal_load;
      end else if (cal_take) begin
        osc_temp_cal_reg_r <= cal_wdata;
      end
    end
  end

  // Loaded flag marks the end of the start-up sequence; it falls only
  // with reset, so software may poll it once after each reset
  always_ff @(posedge clk) begin
    if (reset) begin
      loaded_r <= 1'h0;
    end else if (copy_now) begin
      loaded_r <= 1'h1;
    end
  end

endmodule

// >>> hdl/fcl_pkg.sv
// Types shared by the fuse loader and its users
package fcl_pkg;

  // Operations on the programming/debug port
  typedef enum logic [1:0] {
    FCL_PD_READ = 2'h0,
    FCL_PD_PROGRAM = 2'h1,
    FCL_PD_CLEAR = 2'h2,
    FCL_PD_NOP = 2'h3
  } fcl_pd_op_type;

  // Start-up sequencer states
  typedef enum logic [1:0] {
    FCL_ST_WAIT = 2'h0,
    FCL_ST_COPY = 2'h1,
    FCL_ST_RUN = 2'h2
  } fcl_state_type;

  // Watchdog control A fields fed from the fuses
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } fcl_wdt_ctrl_type;

  // Brown-out control A and B fields
  typedef struct packed {
    logic [2:0] brownout_threshold_sel;
    logic brownout_sample_rate_sel;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } fcl_bod_ctrl_type;

  // Oscillator selection and calibration lock
  typedef struct packed {
    logic osc_cal_lock;
    logic [1:0] osc_freq_sel;
    logic run_16m;
  } fcl_osc_ctrl_type;

  // Oscillator calibration word
  typedef struct packed {
    logic [3:0] temp;
    logic [6:0] freq;
  } fcl_cal_type;

endpackage

// >>> tb/fcl_loader_chk.sv
// Port assertions for the fuse loader
`timescale 1ns/100ps
module fcl_loader_chk #(
  parameter int START_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Access ports
  input wire logic cpu_rd_en,
  input wire logic cpu_wr_en,
  input wire logic cpu_rvalid_r,
  input wire logic pd_req,
  input wire fcl_pkg::fcl_pd_op_type pd_op,
  input wire logic pd_done_r,
  input wire logic cal_wr_en,
  input wire logic cal_wr_rejected_r,
  // Target fields
  input wire fcl_pkg::fcl_wdt_ctrl_type watchdog_control_a_r,
  input wire fcl_pkg::fcl_bod_ctrl_type brownout_control_r,
  input wire logic brownout_lvl_reserved_r,
  input wire fcl_pkg::fcl_osc_ctrl_type osc_ctrl_r,
  input wire logic loaded_r
);
  // Two edges of slack after the copy point, seen START_CYCLES + 1 edges after release
  localparam int LD_MAX = START_CYCLES + 3;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_release; $fell(reset); endsequence
  sequence s_copy; !loaded_r ##[1:LD_MAX] loaded_r; endsequence
  property p_load; s_release |-> s_copy; endproperty
  a_load: assert property (p_load) else $error("copy late");
  property p_rd; cpu_rd_en && !cpu_wr_en |=> cpu_rvalid_r; endproperty
  a_rd: assert property (p_rd) else $error("read lost");
  property p_wr; cpu_wr_en |=> !cpu_rvalid_r; endproperty
  a_wr: assert property (p_wr) else $error("write answered");
  property p_pd;
    pd_req && pd_op != fcl_pkg::FCL_PD_NOP |=> pd_done_r;
  endproperty
  a_pd: assert property (p_pd) else $error("port silent");
  property p_pd_idle;
    !pd_req || pd_op == fcl_pkg::FCL_PD_NOP |=> !pd_done_r;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("stray done");
  property p_hold;
    loaded_r |=> $stable(watchdog_control_a_r) &&
      $stable(brownout_control_r) && $stable(osc_ctrl_r);
  endproperty
  a_hold: assert property (p_hold) else $error("target moved");
  property p_lvl;
    loaded_r |-> brownout_lvl_reserved_r ==
      !(brownout_control_r.brownout_threshold_sel inside {3'h0, 3'h2, 3'h7});
  endproperty
  a_lvl: assert property (p_lvl) else $error("level flag");
  property p_lock;
    cal_wr_en && osc_ctrl_r.osc_cal_lock |=> cal_wr_rejected_r;
  endproperty
  a_lock: assert property (p_lock) else $error("lock ignored");
endmodule

bind fcl_loader fcl_loader_chk #(.START_CYCLES(START_CYCLES)) i_fcl_loader_chk (.*);

// >>> tb/fcl_prog_model.sv
// Behavioural programmer on the programming/debug port
`timescale 1ns/100ps
module fcl_prog_model (
  // Clock
  input wire logic clk,
  // Requests
  output logic pd_req,
  output fcl_pkg::fcl_pd_op_type pd_op,
  output logic [3:0] pd_addr,
  output logic [7:0] pd_wdata,
  // Answers
  input wire logic [7:0] pd_rdata_r,
  input wire logic pd_done_r
);
  // Idle port at time zero
  initial begin
    pd_req = 1'b0;
    pd_op = fcl_pkg::FCL_PD_NOP;
    pd_addr = 4'h0;
    pd_wdata = 8'h00;
  end
  // One request; on release the address and data lines are inverted so stale data cannot pass
  task automatic xfer(input fcl_pkg::fcl_pd_op_type op, input logic [3:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    @(posedge clk);
    #1 pd_req = 1'b1;
    pd_op = op;
    pd_addr = a;
    pd_wdata = (a == 4'h2) ? (d | 8'h7C) : d;
    @(posedge clk);
    #1 pd_req = 1'b0;
    pd_op = fcl_pkg::FCL_PD_NOP;
    pd_addr = ~a;
    pd_wdata = ~pd_wdata;
    ok = pd_done_r;
    q = pd_rdata_r;
  endtask
endmodule

// >>> tb/tb_fcl_loader.sv
// Self-checking bench for the fuse loader
`timescale 1ns/100ps
module tb_fcl_loader;
  localparam fcl_pkg::fcl_cal_type CAL16 = 11'h2A5;
  localparam fcl_pkg::fcl_cal_type CAL20 = 11'h55A;
  logic clk, reset, cpu_rd_en, cpu_wr_en, cpu_rvalid_r, pd_req, pd_done_r;
  logic cal_wr_en, cal_wr_rejected_r, brownout_lvl_reserved_r, loaded_r, ok;
  logic [3:0] cpu_addr, pd_addr;
  logic [7:0] cpu_wdata, cpu_rdata_r, pd_wdata, pd_rdata_r, q;
  fcl_pkg::fcl_pd_op_type pd_op;
  fcl_pkg::fcl_cal_type cal_wdata, osc_temp_cal_reg_r;
  fcl_pkg::fcl_wdt_ctrl_type watchdog_control_a_r;
  fcl_pkg::fcl_bod_ctrl_type brownout_control_r;
  fcl_pkg::fcl_osc_ctrl_type osc_ctrl_r;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  fcl_loader i_fcl_loader (.sig_cal16(CAL16), .sig_cal20(CAL20), .*);
  fcl_prog_model i_fcl_prog_model (.*);
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic reboot(input int n);
    reset = 1'b1;
    repeat (n) @(posedge clk);
    #1 reset = 1'b0;
  endtask
  // Bounded wait for the start-up copy
  task automatic wait_loaded();
    for (int n = 0; n < 20 && !loaded_r; n++) @(posedge clk);
    #1 chk(loaded_r, 1'b1);
  endtask
  task automatic cpu_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 cpu_rd_en = 1'b1;
    cpu_addr = a;
    @(posedge clk);
    #1 cpu_rd_en = 1'b0;
    chk(cpu_rvalid_r, 1'b1);
    chk(cpu_rdata_r, e);
  endtask
  // Shipped image reads, offset 0 before the copy, offset 1 at the copy edge and the rest after it, then lands in the targets
  task automatic t_power();
    cal_wr_en = 1'b1;
    @(posedge clk);
    #1 cal_wr_en = 1'b0;
    chk(cal_wr_rejected_r, 1'b1);
    for (int a = 0; a < 12; a++) begin
      cpu_rd(a[3:0], (a < 2 || a > 10) ? 8'h00 : (a == 2) ? 8'h02 :
        (a == 5) ? 8'hE4 : 8'hFF);
      if (a == 0) chk(loaded_r, 1'b0);
    end
    wait_loaded();
    chk({watchdog_control_a_r, brownout_control_r}, 16'h0000);
    chk(osc_ctrl_r, 4'h4);
    chk(osc_temp_cal_reg_r, CAL20);
    $display("t_power done");
  endtask
  // New fuses wait for a reset; every brown-out and oscillator field code is loaded, half the watchdog codes
  task automatic t_prog();
    logic [2:0] k;
    logic [7:0] w, b, o, pv;
    fcl_pkg::fcl_cal_type c;
    pv = 8'h00;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      w = {1'b1, k, 1'b0, ~k};
      b = {k, k[0], k[1:0], k[1:0]};
      o = {k[0], 5'h1F, k[1:0]};
      i_fcl_prog_model.xfer(fcl_pkg::FCL_PD_PROGRAM, 4'h0, w, q, ok);
      i_fcl_prog_model.xfer(fcl_pkg::FCL_PD_PROGRAM, 4'h1, b, q, ok);
      i_fcl_prog_model.xfer(fcl_pkg::FCL_PD_PROGRAM, 4'h2, o & 8'h83, q, ok);
      i_fcl_prog_model.xfer(fcl_pkg::FCL_PD_READ, 4'h2, 8'h00, q, ok);
      chk(q, o);
      chk(watchdog_control_a_r, pv);
      pv = w;
      reboot(2);
      wait_loaded();
      chk(watchdog_control_a_r, w);
      chk(brownout_control_r, b);
      chk(brownout_lvl_reserved_r, !(k inside {3'h0, 3'h2, 3'h7}));
      chk(osc_ctrl_r, {k[0], k[1:0], k[1:0] == 2'h1});
      c = (k[1:0] == 2'h1) ? CAL16 : CAL20;
      chk(osc_temp_cal_reg_r, c);
      cal_wr_en = 1'b1;
      cal_wdata = {4'h3, k, 4'hC};
      @(posedge clk);
      #1 cal_wr_en = 1'b0;
      chk(cal_wr_rejected_r, k[0]);
      chk(osc_temp_cal_reg_r, k[0] ? c : cal_wdata);
    end
    $display("t_prog done");
  endtask
  // Processor writes are dropped; clear and out-of-range program
  task automatic t_access();
    cpu_wr_en = 1'b1;
    cpu_rd_en = 1'b1;
    cpu_addr = 4'h1;
    cpu_wdata = 8'h77;
    @(posedge clk);
    #1 cpu_wr_en = 1'b0;
    cpu_rd_en = 1'b0;
    chk(cpu_rvalid_r, 1'b0);
    cpu_rd(4'h1, 8'hFF);
    i_fcl_prog_model.xfer(fcl_pkg::FCL_PD_CLEAR, 4'h0, 8'h00, q, ok);
    i_fcl_prog_model.xfer(fcl_pkg::FCL_PD_READ, 4'h0, 8'h00, q, ok);
    chk(q, 8'hFF);
    i_fcl_prog_model.xfer(fcl_pkg::FCL_PD_PROGRAM, 4'hB, 8'h12, q, ok);
    chk(ok, 1'b1);
    cpu_rd(4'hB, 8'h00);
    i_fcl_prog_model.xfer(fcl_pkg::FCL_PD_NOP, 4'h0, 8'h00, q, ok);
    chk(ok, 1'b0);
    $display("t_access done");
  endtask
  // Main sequence
  initial begin
    cpu_rd_en = 1'b0;
    cpu_wr_en = 1'b0;
    cpu_addr = 4'h0;
    cpu_wdata = 8'h00;
    cal_wr_en = 1'b0;
    cal_wdata = 11'h000;
    reboot(12);
    t_power();
    t_prog();
    t_access();
    finish_test();
  end
endmodule
